// ===== inc/irx_pkg.sv
// Shared constants and types of the infrared remote receiver decoder
`default_nettype none
package irx_pkg;
    // Clocking: system clock and low-speed sampling clock
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SAMPLE_HZ = 32_768;
    localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ; // Rounded down, 305 system cycles per tick
    localparam int CNT_W = 8;
    localparam int ADDR_W = 8;

    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_TIMEOUTS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_THRESHOLDS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DATA = 8'h14;

    // Field positions of rx_control_timeouts
    localparam int LEADER_IRQ_EN_BIT = 31;
    localparam int FALL_IRQ_EN_BIT = 30;
    localparam int LEADERLESS_BIT = 25;
    localparam int PHASE_SEL_BIT = 24;
    localparam int LOW_TO_LSB = 8;
    localparam int CYC_TO_LSB = 0;
    localparam int TO_W = 8;
    localparam logic [TO_W-1:0] TIMEOUT_OFF = 8'hff;

    // Field positions of rx_control_thresholds
    localparam int UPPER_LSB = 8;
    localparam int LOWER_LSB = 0;
    localparam int THR_W = 7;

    // Reset values and writable bits
    localparam logic [31:0] TIMEOUTS_RST = 32'h0000_ffff;
    localparam logic [31:0] TIMEOUTS_WMASK = 32'hc300_ffff;
    localparam logic [31:0] THRESH_RST = 32'h0000_0000;
    localparam logic [31:0] THRESH_WMASK = 32'h0000_7f7f;

    // Event flags: status, enable and clear share bits 15..12
    localparam int EV_LSB = 12;
    localparam int EV_W = 4;
    localparam int EV_LEADER = 3;
    localparam int EV_LOW = 2;
    localparam int EV_MAX = 1;
    localparam int EV_FALL = 0;
    localparam int ST_BUSY_BIT = 7;
    localparam int BITCNT_W = 7;

    // Phase patterns
    localparam logic [1:0] PAT_00 = 2'b00;
    localparam logic [1:0] PAT_01 = 2'b01;
    localparam logic [1:0] PAT_10 = 2'b10;

    typedef enum logic {IRX_WAIT_LEADER, IRX_RECEIVE} irx_state_e;
endpackage : irx_pkg
`default_nettype wire

// ===== inc/irx_meas_if.sv
// Measurement results passed from the sampler to the decoder
`timescale 1ns/1ns
`default_nettype none
interface irx_meas_if;
    logic tick;
    logic fall;
    logic level;
    logic [irx_pkg::CNT_W-1:0] cycle_meas;
    logic [irx_pkg::CNT_W-1:0] cycle_run;
    logic [irx_pkg::CNT_W-1:0] low_run;
    modport meas (output tick, output fall, output level, output cycle_meas, output cycle_run, output low_run);
    modport dec (input tick, input fall, input level, input cycle_meas, input cycle_run, input low_run);
endinterface : irx_meas_if
`default_nettype wire

// ===== rtl/irx_cycle_meas.sv
// Sampling tick, falling edge detection and width counters
`timescale 1ns/1ns
`default_nettype none
module irx_cycle_meas #(
    parameter int unsigned DIV = irx_pkg::SAMPLE_DIV // System cycles per sampling tick
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic rc_in, // Conditioned remote input
    irx_meas_if.meas m // Measurement results
);
    import irx_pkg::*;
    localparam int DIV_W = $clog2(DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

    logic [DIV_W-1:0] div_q;
    logic tick_q;
    logic level_q;
    logic fall_q;
    logic [CNT_W-1:0] cyc_q;
    logic [CNT_W-1:0] low_q;
    logic [CNT_W-1:0] meas_q;

    // Counters saturate so a long idle line cannot wrap into a short cycle
    wire div_wrap = (div_q == DIV_LAST);
    wire fall_now = tick_q & level_q & ~rc_in;
    wire [CNT_W-1:0] cyc_inc = (cyc_q == {CNT_W{1'b1}}) ? cyc_q : cyc_q + 1'b1;
    wire [CNT_W-1:0] low_inc = (low_q == {CNT_W{1'b1}}) ? low_q : low_q + 1'b1;

    // Divider to the sampling rate
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_wrap ? '0 : div_q + 1'b1;
            tick_q <= div_wrap;
        end
    end

    // Everything below except fall_q moves only on a sampling tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level_q <= 1'b1;
            fall_q <= 1'b0;
            cyc_q <= '0;
            low_q <= '0;
            meas_q <= '0;
        end else begin
            fall_q <= fall_now;
            if (tick_q) begin
                level_q <= rc_in;
                low_q <= rc_in ? '0 : low_inc;
                if (fall_now) begin
                    meas_q <= cyc_inc;
                    cyc_q <= '0;
                end else begin
                    cyc_q <= cyc_inc;
                end
            end
        end
    end

    assign m.tick = tick_q;
    assign m.fall = fall_q;
    assign m.level = level_q;
    assign m.cycle_meas = meas_q;
    assign m.cycle_run = cyc_q;
    assign m.low_run = low_q;
endmodule : irx_cycle_meas
`default_nettype wire

// ===== rtl/irx_decoder.sv
// Infrared remote receiver: configuration, bit decision and reception control
// Functional notes
// - Leader interrupt only with bit 31 set
// - Falling edge interrupt only with bit 30
// - Bit 25 accepts frames without leader
// - Bit 24 selects cycle or phase decoding
// - Low width timeout ends reception, 0xff off
// - Bit cycle timeout ends reception, 0xff off
// - Cycle above lower threshold is bit 1
// - Phase: above lower gives 01, else 00
// - Phase: above upper threshold gives 10
// - Upper threshold used only in phase mode
// - Sample and count at 32.768 kHz
// - Timeout ends frame, interrupts, awaits leader
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module irx_decoder #(
    parameter int unsigned SAMPLE_DIV_P = irx_pkg::SAMPLE_DIV // System cycles per sampling tick
) (
    input wire logic clk, // System clock, 10 MHz
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic rc_in, // Conditioned remote input
    input wire logic leader_seen, // Pulse from the leader timing logic
    input wire logic [irx_pkg::ADDR_W-1:0] reg_addr, // Register byte address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after the strobe
    output logic irq, // Interrupt, level
    output logic bit_valid, // Pulse with each decided bit
    output logic bit_value, // Decided data bit
    output logic [1:0] phase_pattern, // Decided phase pattern
    output logic frame_done, // Pulse when reception completes
    output logic receiving // High while a frame is received
);
    import irx_pkg::*;

    irx_meas_if mif();

    irx_cycle_meas #(.DIV(SAMPLE_DIV_P)) u_meas (
        .clk(clk),
        .rst_b(rst_b),
        .rc_in(rc_in),
        .m(mif)
    );

    irx_state_e state_q;
    irx_state_e state_d;
    logic [31:0] timeouts_q;
    logic [31:0] thresh_q;
    logic [EV_W-1:0] stat_q;
    logic [EV_W-1:0] irq_en_q;
    logic [31:0] data_q;
    logic [BITCNT_W-1:0] bit_cnt_q;
    logic [31:0] rdata_q;
    logic valid_q;
    logic bit_q;
    logic [1:0] pat_q;
    logic mode_q;
    logic [CNT_W-1:0] last_cyc_q;
    logic done_q;

    // Configuration fields
    wire leader_en = timeouts_q[LEADER_IRQ_EN_BIT];
    wire fall_en = timeouts_q[FALL_IRQ_EN_BIT];
    wire leaderless_en = timeouts_q[LEADERLESS_BIT];
    wire phase_sel = timeouts_q[PHASE_SEL_BIT];
    wire [TO_W-1:0] low_to = timeouts_q[LOW_TO_LSB +: TO_W];
    wire [TO_W-1:0] cyc_to = timeouts_q[CYC_TO_LSB +: TO_W];
    wire [THR_W-1:0] thr_lo = thresh_q[LOWER_LSB +: THR_W];
    wire [THR_W-1:0] thr_hi = thresh_q[UPPER_LSB +: THR_W];

    // Address decode
    wire sel_timeouts = (reg_addr == OFS_TIMEOUTS);
    wire sel_thresh = (reg_addr == OFS_THRESHOLDS);
    wire sel_status = (reg_addr == OFS_STATUS);
    wire sel_clear = (reg_addr == OFS_IRQ_CLEAR);
    wire sel_enable = (reg_addr == OFS_IRQ_ENABLE);
    wire sel_data = (reg_addr == OFS_DATA);

    // Reception control; a leader pulse during a frame is ignored
    wire in_wait = (state_q == IRX_WAIT_LEADER);
    wire in_recv = (state_q == IRX_RECEIVE);
    wire start_leader = in_wait & leader_seen;
    wire start_noleader = in_wait & mif.fall & leaderless_en & ~leader_seen;
    wire low_hit = in_recv & (mif.low_run == low_to) & (low_to != TIMEOUT_OFF);
    wire cyc_hit = in_recv & (mif.cycle_run == cyc_to) & (cyc_to != TIMEOUT_OFF);
    wire end_rx = low_hit | cyc_hit;
    wire bit_fall = in_recv & mif.fall & ~end_rx;

    // Bit and pattern decision on the measured cycle
    wire above_lo = mif.cycle_meas > {1'b0, thr_lo};
    wire above_hi = phase_sel & (mif.cycle_meas > {1'b0, thr_hi});
    wire [1:0] pat_d = !phase_sel ? PAT_00 : (above_hi ? PAT_10 : (above_lo ? PAT_01 : PAT_00));

    // Events into the sticky status; a set in the clearing cycle wins
    wire [EV_W-1:0] ev;
    assign ev[EV_LEADER] = start_leader & leader_en;
    assign ev[EV_LOW] = low_hit;
    assign ev[EV_MAX] = cyc_hit;
    assign ev[EV_FALL] = (bit_fall | start_noleader) & fall_en;
    wire [EV_W-1:0] clr_mask = (reg_wr & sel_clear) ? reg_wdata[EV_LSB +: EV_W] : '0;
    wire [EV_W-1:0] stat_d = (stat_q & ~clr_mask) | ev;
    wire [BITCNT_W-1:0] bit_cnt_inc = (bit_cnt_q == {BITCNT_W{1'b1}}) ? bit_cnt_q : bit_cnt_q + 1'b1;

    // Read selection; unmapped addresses and the clear register read zero
    wire [31:0] status_word = {16'h0000, stat_q, 4'h0, in_recv, bit_cnt_q};
    wire [31:0] rd_val = sel_timeouts ? timeouts_q :
                         sel_thresh ? thresh_q :
                         sel_status ? status_word :
                         sel_enable ? {16'h0000, irq_en_q, 12'h000} :
                         sel_data ? data_q : 32'h0000_0000;

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            IRX_WAIT_LEADER: begin
                if (start_leader || start_noleader) begin
                    state_d = IRX_RECEIVE;
                end
            end
            IRX_RECEIVE: begin
                if (end_rx) begin
                    state_d = IRX_WAIT_LEADER;
                end
            end
            default: begin
                state_d = IRX_WAIT_LEADER;
            end
        endcase
    end

    // Software registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timeouts_q <= TIMEOUTS_RST;
            thresh_q <= THRESH_RST;
            irq_en_q <= '0;
            stat_q <= '0;
            rdata_q <= '0;
        end else begin
            if (reg_wr && sel_timeouts) begin
                timeouts_q <= reg_wdata & TIMEOUTS_WMASK;
            end
            if (reg_wr && sel_thresh) begin
                thresh_q <= reg_wdata & THRESH_WMASK;
            end
            if (reg_wr && sel_enable) begin
                irq_en_q <= reg_wdata[EV_LSB +: EV_W];
            end
            stat_q <= stat_d;
            rdata_q <= reg_rd ? rd_val : 32'h0000_0000;
        end
    end

    // Frame state, bit counter and shift buffer (last bit lands in bit 0)
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= IRX_WAIT_LEADER;
            bit_cnt_q <= '0;
            data_q <= '0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            done_q <= end_rx;
            if (start_leader || start_noleader) begin
                bit_cnt_q <= '0;
            end else if (bit_fall) begin
                bit_cnt_q <= bit_cnt_inc;
                data_q <= {data_q[30:0], above_lo};
            end
        end
    end

    // Decision outputs held from flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            valid_q <= 1'b0;
            bit_q <= 1'b0;
            pat_q <= PAT_00;
            mode_q <= 1'b0;
            last_cyc_q <= '0;
        end else begin
            valid_q <= bit_fall;
            if (bit_fall) begin
                bit_q <= above_lo;
                pat_q <= pat_d;
                mode_q <= phase_sel;
                last_cyc_q <= mif.cycle_meas;
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = |(stat_q & irq_en_q);
    assign bit_valid = valid_q;
    assign bit_value = bit_q;
    assign phase_pattern = pat_q;
    assign frame_done = done_q;
    assign receiving = in_recv;

    // Checks on the decoder, all in the system clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_leader_irq;
        $rose(stat_q[EV_LEADER]) |-> $past(leader_en);
    endproperty
    a_leader_irq: assert property (p_leader_irq) else $error("Leader flag set while disabled");

    property p_fall_irq;
        $rose(stat_q[EV_FALL]) |-> $past(fall_en);
    endproperty
    a_fall_irq: assert property (p_fall_irq) else $error("Falling edge flag set while disabled");

    property p_leaderless;
        (in_wait && mif.fall && !leader_seen && !leaderless_en) |=> (state_q == IRX_WAIT_LEADER);
    endproperty
    a_leaderless: assert property (p_leaderless) else $error("Frame started without leader while disallowed");

    property p_mode;
        valid_q |-> (mode_q == $past(phase_sel));
    endproperty
    a_mode: assert property (p_mode) else $error("Decode mode not taken from select bit");

    property p_low_timeout;
        (in_recv && mif.low_run == low_to && low_to != TIMEOUT_OFF) |=> (in_wait && stat_q[EV_LOW] && frame_done);
    endproperty
    a_low_timeout: assert property (p_low_timeout) else $error("Low width timeout did not end frame");

    property p_cyc_timeout;
        (in_recv && mif.cycle_run == cyc_to && cyc_to != TIMEOUT_OFF) |=> (in_wait && stat_q[EV_MAX] && frame_done);
    endproperty
    a_cyc_timeout: assert property (p_cyc_timeout) else $error("Bit cycle timeout did not end frame");

    property p_bit_class;
        (valid_q && $stable(thresh_q)) |-> (bit_q == (last_cyc_q > {1'b0, thr_lo}));
    endproperty
    a_bit_class: assert property (p_bit_class) else $error("Data bit misclassified");

    property p_pat_low;
        (valid_q && mode_q && $stable(thresh_q) && last_cyc_q <= {1'b0, thr_hi}) |->
            (pat_q == ((last_cyc_q > {1'b0, thr_lo}) ? PAT_01 : PAT_00));
    endproperty
    a_pat_low: assert property (p_pat_low) else $error("Phase pattern 00 or 01 wrong");

    property p_pat_high;
        (valid_q && mode_q && $stable(thresh_q) && last_cyc_q > {1'b0, thr_hi}) |-> (pat_q == PAT_10);
    endproperty
    a_pat_high: assert property (p_pat_high) else $error("Phase pattern 10 missing");

    property p_upper_ignored;
        (valid_q && !mode_q) |-> (pat_q == PAT_00);
    endproperty
    a_upper_ignored: assert property (p_upper_ignored) else $error("Upper threshold used in cycle mode");

    property p_tick_rate;
        mif.tick |=> (!mif.tick) [*8];
    endproperty
    a_tick_rate: assert property (p_tick_rate) else $error("Sampling ticks too close");

    property p_measure;
        (in_recv && mif.fall && !end_rx) |=> (valid_q && last_cyc_q == $past(mif.cycle_meas));
    endproperty
    a_measure: assert property (p_measure) else $error("Measured cycle not decided");

    // The edge detector must see the line low in the cycle in which it reports a fall
    property p_fall_level;
        mif.fall |-> !mif.level;
    endproperty
    a_fall_level: assert property (p_fall_level) else $error("Fall reported while line high");

    property p_leader_start;
        (in_wait && leader_seen) |=> in_recv;
    endproperty
    a_leader_start: assert property (p_leader_start) else $error("Leader did not start a frame");

    // An all-ones field must never end a frame, however long the line stays put
    property p_low_off;
        (low_to == TIMEOUT_OFF) |=> !$rose(stat_q[EV_LOW]);
    endproperty
    a_low_off: assert property (p_low_off) else $error("Disabled low width timeout fired");

    property p_cyc_off;
        (cyc_to == TIMEOUT_OFF) |=> !$rose(stat_q[EV_MAX]);
    endproperty
    a_cyc_off: assert property (p_cyc_off) else $error("Disabled bit cycle timeout fired");

    // Flags are sticky: only a write of one to the clear register drops them
    property p_low_sticky;
        (stat_q[EV_LOW] && !(reg_wr && sel_clear && reg_wdata[EV_LSB + EV_LOW])) |=> stat_q[EV_LOW];
    endproperty
    a_low_sticky: assert property (p_low_sticky) else $error("Low width flag lost without clear");

    property p_end_irq;
        (((low_hit && irq_en_q[EV_LOW]) || (cyc_hit && irq_en_q[EV_MAX])) && !(reg_wr && sel_enable)) |=> irq;
    endproperty
    a_end_irq: assert property (p_end_irq) else $error("Frame end raised no interrupt");

    cover property (start_leader ##[1:1000] bit_fall);
    cover property (start_noleader);
    cover property (valid_q && pat_q == PAT_10);
    cover property (low_hit && irq);
endmodule : irx_decoder
`default_nettype wire

// ===== tb/irx_rc_model.sv
// Behavioural remote transmitter driving the conditioned receiver input
`timescale 1ns/1ns
`default_nettype none
module irx_rc_model #(
    parameter int DIV = 12 // System cycles per sampling tick
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Reset, active low
    output logic rc_in, // Remote signal, rests high
    output logic busy // High while cycles are pending
);
    int per_q[$];
    int low_q[$];
    int cnt;
    int hi_at;

    // Queue one bit cycle: low for low ticks, next fall after per ticks
    task automatic push(input int per, input int low);
        per_q.push_back(per);
        low_q.push_back(low);
    endtask : push

    // Cycles run back to back so fall spacing is exact in ticks
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rc_in <= 1'b1;
            cnt = 0;
            hi_at = -1;
        end else if (cnt > 0) begin
            cnt = cnt - 1;
            if (cnt == hi_at) begin
                rc_in <= 1'b1;
            end
        end else if (per_q.size() > 0) begin
            rc_in <= 1'b0;
            cnt = per_q[0] * DIV - 1;
            hi_at = (per_q[0] - low_q[0]) * DIV - 1;
            void'(per_q.pop_front());
            void'(low_q.pop_front());
        end else begin
            // Released line returns to its idle high level
            rc_in <= 1'b1;
        end
        busy <= (cnt > 0) || (per_q.size() > 0);
    end
endmodule : irx_rc_model
`default_nettype wire

// ===== tb/tb_irx_decoder.sv
// Self-checking bench of the infrared receiver decoder
`timescale 1ns/1ns
`default_nettype none
module tb_irx_decoder;
    import irx_pkg::*;
    localparam int DIV = 12;
    logic clk, rst_b, rc_in, leader_seen, reg_wr, reg_rd, irq, bit_valid, bit_value, frame_done, receiving, rc_busy;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [1:0] phase_pattern;
    logic [2:0] bq[$];
    int failures, cmp_count, fd_cnt;

    irx_decoder #(.SAMPLE_DIV_P(DIV)) i_irx_decoder (.clk(clk), .rst_b(rst_b), .rc_in(rc_in),
        .leader_seen(leader_seen), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .bit_valid(bit_valid), .bit_value(bit_value),
        .phase_pattern(phase_pattern), .frame_done(frame_done), .receiving(receiving));
    irx_rc_model #(.DIV(DIV)) i_irx_rc_model (.clk(clk), .rst_b(rst_b), .rc_in(rc_in), .busy(rc_busy));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Record decided bits and finished frames as they are emitted
    always @(posedge clk) begin
        if (bit_valid === 1'b1) bq.push_back({phase_pattern, bit_value});
        if (frame_done === 1'b1) fd_cnt++;
    end

    task automatic report_and_stop();
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : rd_chk

    // Bounded wait for the next end of frame, then for the line to go idle
    task automatic wait_frame(input int n0);
        int k;
        k = 0;
        while ((fd_cnt == n0 || rc_busy !== 1'b0) && k < 3000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 3000) begin
            $display("[ERR] frame_done expected 1 seen 0");
            failures++;
            report_and_stop();
        end
        #1;
    endtask : wait_frame

    task automatic pulse_leader();
        @(posedge clk);
        leader_seen <= 1'b1;
        @(posedge clk);
        leader_seen <= 1'b0;
        #1;
        chk("receiving", 32'h1, {31'h0, receiving});
    endtask : pulse_leader

    task automatic t_regs();
        rd_chk("timeouts reset", OFS_TIMEOUTS, 32'h0000ffff);
        rd_chk("thresholds reset", OFS_THRESHOLDS, 32'h0);
        wr(OFS_TIMEOUTS, 32'hffffffff);
        wr(OFS_THRESHOLDS, 32'hffffffff);
        wr(OFS_STATUS, 32'hffffffff);
        rd_chk("timeouts mask", OFS_TIMEOUTS, 32'hc300ffff);
        rd_chk("thresholds mask", OFS_THRESHOLDS, 32'h00007f7f);
        rd_chk("status", OFS_STATUS, 32'h0);
        rd_chk("unmapped", 8'h40, 32'h0);
        @(posedge clk);
        #1;
        chk("rdata idle", 32'h0, reg_rdata);
    endtask : t_regs

    // Leaderless frame in cycle mode, ended by the bit cycle timeout of 30 ticks
    task automatic t_cycle();
        logic [2:0] exp[4] = '{3'b001, 3'b000, 3'b001, 3'b000};
        int n0;
        wr(OFS_IRQ_ENABLE, 32'h0000f000);
        wr(OFS_TIMEOUTS, 32'h4200ff1e);
        wr(OFS_THRESHOLDS, 32'h00000205); // Upper below lower: must not matter here
        bq.delete();
        n0 = fd_cnt;
        i_irx_rc_model.push(8, 2);
        i_irx_rc_model.push(5, 2);
        i_irx_rc_model.push(6, 2);
        i_irx_rc_model.push(3, 2);
        i_irx_rc_model.push(9, 2);
        wait_frame(n0);
        chk("bit count", 32'd4, 32'(bq.size()));
        for (int i = 0; i < 4 && i < bq.size(); i++) begin
            chk("cycle bit", {29'h0, exp[i]}, {29'h0, bq[i]});
        end
        rd_chk("status", OFS_STATUS, 32'h00003004);
        rd_chk("data", OFS_DATA, 32'h0000000a);
        chk("irq", 32'h1, {31'h0, irq});
        chk("receiving", 32'h0, {31'h0, receiving});
        wr(OFS_IRQ_CLEAR, 32'h0000f000);
    endtask : t_cycle

    // Leader frame in phase mode, ended by a low width of 10 ticks
    task automatic t_phase();
        logic [2:0] exp[4] = '{3'b000, 3'b011, 3'b011, 3'b101};
        int n0;
        wr(OFS_IRQ_ENABLE, 32'h0);
        wr(OFS_TIMEOUTS, 32'h81000aff);
        wr(OFS_THRESHOLDS, 32'h00000704);
        pulse_leader();
        rd_chk("status", OFS_STATUS, 32'h00008080);
        bq.delete();
        n0 = fd_cnt;
        i_irx_rc_model.push(4, 2);
        i_irx_rc_model.push(5, 2);
        i_irx_rc_model.push(7, 2);
        i_irx_rc_model.push(8, 2);
        i_irx_rc_model.push(20, 20);
        wait_frame(n0);
        chk("bit count", 32'd5, 32'(bq.size()));
        for (int i = 0; i < 4 && i + 1 < bq.size(); i++) begin
            chk("phase pattern", {29'h0, exp[i]}, {29'h0, bq[i + 1]});
        end
        rd_chk("status", OFS_STATUS, 32'h0000c005);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(OFS_IRQ_ENABLE, 32'h00004000);
        chk("irq", 32'h1, {31'h0, irq});
        wr(OFS_IRQ_CLEAR, 32'h00004000);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd_chk("status", OFS_STATUS, 32'h00008005);
        wr(OFS_IRQ_CLEAR, 32'h00008000);
    endtask : t_phase

    // Falls without leaderless mode start nothing; a leader with its interrupt disabled leaves the flag clear
    task automatic t_leader_off();
        wr(OFS_TIMEOUTS, 32'h0000ffff);
        wr(OFS_IRQ_ENABLE, 32'h0000f000);
        i_irx_rc_model.push(4, 2);
        i_irx_rc_model.push(4, 2);
        repeat (120) @(posedge clk);
        rd_chk("status no leader", OFS_STATUS, 32'h00000005);
        pulse_leader();
        rd_chk("status", OFS_STATUS, 32'h00000080);
        chk("irq", 32'h0, {31'h0, irq});
    endtask : t_leader_off

    initial begin
        rst_b = 1'b0;
        leader_seen = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        failures = 0;
        cmp_count = 0;
        fd_cnt = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_cycle();
        t_phase();
        t_leader_off();
        report_and_stop();
    end
endmodule : tb_irx_decoder
`default_nettype wire
